// *** design/isse_exec.v ***
// Notes on behaviour
// - shift low word right, zero fill, sign-extend
// - non-word shift operand gives any result
// - no-op break is left shift zero by one
// - group ends before break no-op, issues alone
// - next instruction issues no earlier than after
// - single issue: no-op still takes a slot
// - superscalar: break no-op issues one cycle late
// - function 100010 gives signed word difference
// - overflow raises trap, destination unchanged
// - no overflow: sign-extended difference written
// - function 100011 wraps, never traps
// - non-word subtract operands give any result
// - indexed double store at base plus index
// - indexed double store ignores low three bits
// - sixteen register mode: indexed store undefined
// - indexed store: only unusable, reserved, translation
// - word store low word at base plus offset
// - word store misaligned raises address error
// - endian swap on address only; big-endian flag sets lane and shift
// - word store: translation and address errors only
// - opcode 111001 stores low float word
// - float word store misaligned raises address error
`include "isse_defs.vh"
module isse_exec #(
    parameter SUPERSCALAR = 1
) (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire        ISSUE_VALID,
    input  wire [31:0] ISSUE_INSTR,
    input  wire [63:0] SRC_A,
    input  wire [63:0] SRC_B,
    input  wire [63:0] FP_DATA,
    input  wire        FP_USABLE,
    input  wire        FP16_MODE,
    input  wire        CPU_BIG_ENDIAN_FLAG,
    input  wire        USER_ENDIAN_SWAP_FLAG,
    input  wire        XLATE_DONE,
    input  wire [2:0]  XLATE_EXC,
    input  wire [39:0] XLATE_PADDR,
    output reg         ISSUE_ACCEPT,
    output reg         GROUP_END,
    output reg         ISSUE_ALONE,
    output reg         WB_EN,
    output reg  [4:0]  WB_REG,
    output reg  [63:0] WB_DATA,
    output reg         XLATE_REQ,
    output reg  [63:0] XLATE_VADDR,
    output reg         ST_EN,
    output reg  [39:0] ST_PADDR,
    output reg  [63:0] ST_DATA,
    output reg  [7:0]  ST_BE,
    output reg         ST_SIZE,
    output reg         EXC_VALID,
    output reg  [2:0]  EXC_CODE
);
    // =================================================================
    // decode helpers
    localparam S_IDLE = 1'b0;
    localparam S_XLAT = 1'b1;

    function is_store;
        input [31:0] ins;
        begin
            is_store = (ins[`ISSE_OP_HI:`ISSE_OP_LO] == `ISSE_OP_SW) ||
                       (ins[`ISSE_OP_HI:`ISSE_OP_LO] == `ISSE_OP_FPSW) ||
                       (ins[`ISSE_OP_HI:`ISSE_OP_LO] == `ISSE_OP_FPIDX &&
                        ins[`ISSE_FN_HI:`ISSE_FN_LO] == `ISSE_FN_FPSDX);
        end
    endfunction

    wire [5:0]  op     = ISSUE_INSTR[`ISSE_OP_HI:`ISSE_OP_LO];
    wire [5:0]  fn     = ISSUE_INSTR[`ISSE_FN_HI:`ISSE_FN_LO];
    wire [4:0]  rd     = ISSUE_INSTR[`ISSE_RD_HI:`ISSE_RD_LO];
    wire [4:0]  sa     = ISSUE_INSTR[`ISSE_SA_HI:`ISSE_SA_LO];
    wire        regfmt = (op == `ISSE_OP_REGFMT);
    wire        nopbrk = (ISSUE_INSTR == `ISSE_NOPBRK_WORD);
    wire        op_shr = regfmt && fn == `ISSE_FN_SHRV && sa == 5'h00;
    wire        op_sbt = regfmt && fn == `ISSE_FN_SUBT && sa == 5'h00;
    wire        op_sbw = regfmt && fn == `ISSE_FN_SUBW && sa == 5'h00;
    wire        op_sw  = (op == `ISSE_OP_SW);
    wire        op_fsw = (op == `ISSE_OP_FPSW);
    wire        op_fsd = (op == `ISSE_OP_FPIDX) && fn == `ISSE_FN_FPSDX && sa == 5'h00;
    wire        fp_op  = op_fsw || op_fsd;

    wire [63:0] shr_res;
    wire [63:0] sub_res;
    wire        sub_ovf;

    isse_alu u_alu (
        .a       (SRC_A),
        .b       (SRC_B),
        .amt     (SRC_B[4:0]),
        .shr_res (shr_res),
        .sub_res (sub_res),
        .sub_ovf (sub_ovf)
    );

    // SRC_A is the shifted word for the shift; SRC_B carries the amount
    wire [63:0] imm_ext = {{48{ISSUE_INSTR[15]}}, ISSUE_INSTR[15:0]};
    wire [63:0] ea_imm  = SRC_A + imm_ext;
    wire [63:0] ea_idx  = SRC_A + SRC_B;

    // =================================================================
    // store pending state
    reg        state_r;
    reg        st_kind_r;
    reg [63:0] st_word_r;
    reg [63:0] st_va_r;
    reg        issued_alone_r;

    wire busy    = (state_r == S_XLAT);
    // break no-op ends the previous group: accept it only in a fresh slot
    wire nop_ok  = !SUPERSCALAR || issued_alone_r;
    wire take    = ISSUE_VALID && !busy && (!nopbrk || nop_ok);

    // byte lane selection shared by both word stores
    wire [2:0] bsel = st_va_r[2:0] ^ {CPU_BIG_ENDIAN_FLAG, 2'b00};

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r        <= S_IDLE;
            st_kind_r      <= `ISSE_SZ_WORD;
            st_word_r      <= 64'h0;
            st_va_r        <= 64'h0;
            issued_alone_r <= 1'b0;
            ISSUE_ACCEPT   <= 1'b0;
            GROUP_END      <= 1'b0;
            ISSUE_ALONE    <= 1'b0;
            WB_EN          <= 1'b0;
            WB_REG         <= 5'h00;
            WB_DATA        <= 64'h0;
            XLATE_REQ      <= 1'b0;
            XLATE_VADDR    <= 64'h0;
            ST_EN          <= 1'b0;
            ST_PADDR       <= 40'h0;
            ST_DATA        <= 64'h0;
            ST_BE          <= 8'h00;
            ST_SIZE        <= `ISSE_SZ_WORD;
            EXC_VALID      <= 1'b0;
            EXC_CODE       <= `ISSE_EXC_NONE;
        end else begin
            ISSUE_ACCEPT <= take;
            // only the refused first offer ends the group; the taken retry must not
            GROUP_END    <= ISSUE_VALID && !busy && nopbrk && !take;
            ISSUE_ALONE  <= take && nopbrk;
            WB_EN        <= 1'b0;
            XLATE_REQ    <= 1'b0;
            ST_EN        <= 1'b0;
            EXC_VALID    <= 1'b0;
            EXC_CODE     <= `ISSE_EXC_NONE;
            // first cycle after a break stall is a fresh group
            issued_alone_r <= ISSUE_VALID && !busy && nopbrk && !take;
            case (state_r)
            S_IDLE: begin
                if (take) begin
                    if (nopbrk) begin
                        WB_EN <= 1'b0;
                    end else if (op_shr) begin
                        WB_EN   <= (rd != 5'h00);
                        WB_REG  <= rd;
                        WB_DATA <= shr_res;
                    end else if (op_sbt && sub_ovf) begin
                        EXC_VALID <= 1'b1;
                        EXC_CODE  <= `ISSE_EXC_OVF;
                    end else if (op_sbt || op_sbw) begin
                        WB_EN   <= (rd != 5'h00);
                        WB_REG  <= rd;
                        WB_DATA <= sub_res;
                    end else if (fp_op && !FP_USABLE) begin
                        EXC_VALID <= 1'b1;
                        EXC_CODE  <= `ISSE_EXC_CPU;
                    end else if ((op_sw && ea_imm[1:0] != 2'b00) ||
                                 (op_fsw && ea_imm[1:0] != 2'b00)) begin
                        EXC_VALID <= 1'b1;
                        EXC_CODE  <= `ISSE_EXC_ADES;
                    end else if (op_sw || op_fsw) begin
                        state_r     <= S_XLAT;
                        st_kind_r   <= `ISSE_SZ_WORD;
                        st_word_r   <= op_sw ? SRC_B : FP_DATA;
                        st_va_r     <= ea_imm;
                        XLATE_REQ   <= 1'b1;
                        XLATE_VADDR <= ea_imm;
                    end else if (op_fsd) begin
                        // FP16_MODE leaves this store undefined; no register_format_group case
                        state_r     <= S_XLAT;
                        st_kind_r   <= `ISSE_SZ_DWORD;
                        st_word_r   <= FP_DATA;
                        st_va_r     <= {ea_idx[63:3], 3'b000};
                        XLATE_REQ   <= 1'b1;
                        XLATE_VADDR <= {ea_idx[63:3], 3'b000};
                    end else if (!is_store(ISSUE_INSTR) && !regfmt) begin
                        EXC_VALID <= 1'b1;
                        EXC_CODE  <= `ISSE_EXC_RSVD;
                    end
                end
            end
            S_XLAT: begin
                if (XLATE_DONE) begin
                    state_r <= S_IDLE;
                    if (XLATE_EXC != `ISSE_EXC_NONE) begin
                        EXC_VALID <= 1'b1;
                        EXC_CODE  <= XLATE_EXC;
                    end else if (st_kind_r == `ISSE_SZ_DWORD) begin
                        ST_EN    <= 1'b1;
                        ST_SIZE  <= `ISSE_SZ_DWORD;
                        ST_PADDR <= {XLATE_PADDR[39:3], 3'b000};
                        ST_DATA  <= st_word_r;
                        ST_BE    <= 8'hff;
                    end else begin
                        ST_EN    <= 1'b1;
                        ST_SIZE  <= `ISSE_SZ_WORD;
                        ST_PADDR <= {XLATE_PADDR[39:3],
                                     XLATE_PADDR[2] ^ USER_ENDIAN_SWAP_FLAG,
                                     XLATE_PADDR[1:0]};
                        ST_DATA  <= bsel[2] ? {st_word_r[31:0], 32'h0}
                                            : {32'h0, st_word_r[31:0]};
                        ST_BE    <= bsel[2] ? 8'hf0 : 8'h0f;
                    end
                end
            end
            default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // isse_exec

// *** design/isse_defs.vh ***
`ifndef ISSE_DEFS_VH
`define ISSE_DEFS_VH
// =====================================================================
// instruction field positions
`define ISSE_OP_HI        31
`define ISSE_OP_LO        26
`define ISSE_RS_HI        25
`define ISSE_RS_LO        21
`define ISSE_RT_HI        20
`define ISSE_RT_LO        16
`define ISSE_RD_HI        15
`define ISSE_RD_LO        11
`define ISSE_SA_HI        10
`define ISSE_SA_LO        6
`define ISSE_FN_HI        5
`define ISSE_FN_LO        0
// =====================================================================
// opcodes and function codes
`define ISSE_OP_REGFMT    6'h00
`define ISSE_OP_FPIDX     6'h13
`define ISSE_OP_SW        6'h2b
`define ISSE_OP_FPSW      6'h39
`define ISSE_FN_SHL       6'h00
`define ISSE_FN_SHRV      6'h06
`define ISSE_FN_SUBT      6'h22
`define ISSE_FN_SUBW      6'h23
`define ISSE_FN_FPSDX     6'h0d
`define ISSE_NOPBRK_WORD  32'h00000040
// =====================================================================
// exception codes
`define ISSE_EXC_NONE     3'h0
`define ISSE_EXC_OVF      3'h1
`define ISSE_EXC_ADES     3'h2
`define ISSE_EXC_RSVD     3'h3
`define ISSE_EXC_CPU      3'h4
`define ISSE_EXC_TLBL     3'h5
`define ISSE_EXC_TLBINV   3'h6
`define ISSE_EXC_TLBMOD   3'h7
// =====================================================================
// store sizes
`define ISSE_SZ_WORD      1'b0
`define ISSE_SZ_DWORD     1'b1
`endif

// *** design/isse_alu.v ***
`include "isse_defs.vh"
module isse_alu (
    input  wire [63:0] a,
    input  wire [63:0] b,
    input  wire [4:0]  amt,
    output wire [63:0] shr_res,
    output wire [63:0] sub_res,
    output wire        sub_ovf
);
    wire [31:0] shr_w;
    wire [32:0] diff;
    assign shr_w   = a[31:0] >> amt;
    assign shr_res = {{32{shr_w[31]}}, shr_w};
    // 33-bit extension exposes overflow as a bit-32/bit-31 mismatch
    assign diff    = {a[31], a[31:0]} - {b[31], b[31:0]};
    assign sub_ovf = diff[32] ^ diff[31];
    assign sub_res = {{32{diff[31]}}, diff[31:0]};
endmodule // isse_alu

// *** dv/isse_exec_properties.sv ***
// ============================================================
// port relations of the execute slice
module isse_exec_props #(
    parameter SUPERSCALAR = 1
) (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        XLATE_DONE,
    input wire logic [2:0]  XLATE_EXC,
    input wire logic        ISSUE_ACCEPT,
    input wire logic        GROUP_END,
    input wire logic        ISSUE_ALONE,
    input wire logic        WB_EN,
    input wire logic        XLATE_REQ,
    input wire logic        ST_EN,
    input wire logic [39:0] ST_PADDR,
    input wire logic [7:0]  ST_BE,
    input wire logic        ST_SIZE,
    input wire logic        EXC_VALID,
    input wire logic [2:0]  EXC_CODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    property p_wb_acc; WB_EN |-> ISSUE_ACCEPT; endproperty
    a_wb_acc: assert property (p_wb_acc) else $error("write-back without issue");
    property p_exc_quiet; EXC_VALID |-> !WB_EN && !ST_EN; endproperty
    a_exc_quiet: assert property (p_exc_quiet) else $error("update beside exception");
    property p_st_done; XLATE_DONE && XLATE_EXC == 3'h0 |=> ST_EN && !EXC_VALID; endproperty
    a_st_done: assert property (p_st_done) else $error("store missing after answer");
    property p_xexc;
        XLATE_DONE && XLATE_EXC != 3'h0 |=> EXC_VALID && !ST_EN && EXC_CODE == $past(XLATE_EXC);
    endproperty
    a_xexc: assert property (p_xexc) else $error("translation fault not passed on");
    property p_dword; ST_EN && ST_SIZE |-> ST_PADDR[2:0] == 3'h0 && ST_BE == 8'hff; endproperty
    a_dword: assert property (p_dword) else $error("double store not aligned");
    property p_word_be; ST_EN && !ST_SIZE |-> ST_BE == 8'h0f || ST_BE == 8'hf0; endproperty
    a_word_be: assert property (p_word_be) else $error("word lane wrong");
    property p_break; GROUP_END |=> ISSUE_ALONE && ISSUE_ACCEPT; endproperty
    a_break: assert property (p_break) else $error("break no-op not issued alone");
    property p_alone; ISSUE_ALONE |-> !WB_EN && !EXC_VALID ##1 !ISSUE_ALONE; endproperty
    a_alone: assert property (p_alone) else $error("break no-op changed state");
    property p_ovf; EXC_VALID && EXC_CODE == 3'h1 |-> ISSUE_ACCEPT && !XLATE_REQ; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow out of step");
endmodule // isse_exec_props

bind isse_exec isse_exec_props #(.SUPERSCALAR(SUPERSCALAR)) isse_exec_props_inst (.CLK, .RSTN,
    .XLATE_DONE, .XLATE_EXC, .ISSUE_ACCEPT, .GROUP_END, .ISSUE_ALONE, .WB_EN, .XLATE_REQ, .ST_EN,
    .ST_PADDR, .ST_BE, .ST_SIZE, .EXC_VALID, .EXC_CODE);

// *** dv/isse_xlate_model.sv ***
// ============================================================
// translation unit: identity map, set latency and fault
module isse_xlate_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        req,
    input  wire logic [63:0] vaddr,
    input  wire logic [2:0]  exc_sel,
    input  wire logic [1:0]  lat,
    output logic             done,
    output logic [2:0]       exc,
    output logic [39:0]      paddr
);
    logic [1:0]  cnt;
    logic        busy;
    logic [39:0] va;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {done, busy, cnt, exc, paddr, va} <= '0;
        end else begin
            done  <= 1'b0;
            // outside an answer the lines toggle, never hold the last value
            paddr <= ~paddr;
            exc   <= ~exc;
            if (req) begin
                busy <= 1'b1;
                cnt  <= lat;
                va   <= vaddr[39:0];
            end else if (busy && cnt == 2'h0) begin
                {done, busy, paddr, exc} <= {2'b10, va, exc_sel};
            end else if (busy) begin
                cnt <= cnt - 2'h1;
            end
        end
    end
endmodule // isse_xlate_model

// *** dv/test_int_subtract_store_exec.sv ***
`include "isse_defs.vh"
module test_int_subtract_store_exec;
timeunit 1ns;
timeprecision 1ps;
// ============================================================
// signals named as the ports they drive, except esel for exc_sel
logic        CLK = 0, RSTN = 0, ISSUE_VALID = 0, FP_USABLE = 1;
logic        CPU_BIG_ENDIAN_FLAG = 0, USER_ENDIAN_SWAP_FLAG = 0;
logic [31:0] ISSUE_INSTR = '0;
logic [63:0] SRC_A = '0, SRC_B = '0, FP_DATA = 64'h0123456789abcdef;
logic [2:0]  esel = '0, ex;
logic [1:0]  lat = '0;
wire         XLATE_DONE, ISSUE_ACCEPT, GROUP_END, ISSUE_ALONE, WB_EN, XLATE_REQ, ST_EN;
wire         ST_SIZE, EXC_VALID;
wire  [2:0]  XLATE_EXC, EXC_CODE;
wire  [39:0] XLATE_PADDR, ST_PADDR;
wire  [63:0] WB_DATA, XLATE_VADDR, ST_DATA;
wire  [7:0]  ST_BE;
wire  [4:0]  WB_REG;
int          fails = 0, tests_run = 0, n_acc, n_ge, n_al, n_wb, n_exc, n_xr, n_st;
logic [63:0] wb_d, sd;
logic [39:0] sp;
logic [7:0]  sb;
logic [4:0]  wb_r;
logic        ss;
always #5 CLK = ~CLK;
isse_exec #(.SUPERSCALAR(1)) isse_exec_inst (.CLK, .RSTN, .ISSUE_VALID, .ISSUE_INSTR, .SRC_A,
    .SRC_B, .FP_DATA, .FP_USABLE, .FP16_MODE(1'b0), .CPU_BIG_ENDIAN_FLAG, .USER_ENDIAN_SWAP_FLAG,
    .XLATE_DONE, .XLATE_EXC, .XLATE_PADDR, .ISSUE_ACCEPT, .GROUP_END, .ISSUE_ALONE, .WB_EN,
    .WB_REG, .WB_DATA, .XLATE_REQ, .XLATE_VADDR, .ST_EN, .ST_PADDR, .ST_DATA, .ST_BE, .ST_SIZE,
    .EXC_VALID, .EXC_CODE);
isse_xlate_model isse_xlate_model_inst (.clk(CLK), .rstn(RSTN), .req(XLATE_REQ),
    .vaddr(XLATE_VADDR), .exc_sel(esel), .lat, .done(XLATE_DONE), .exc(XLATE_EXC),
    .paddr(XLATE_PADDR));
// ============================================================
// pulse collector: sees each one-cycle output at the edge ending it
always @(posedge CLK) begin
    n_acc += ISSUE_ACCEPT;
    n_ge  += GROUP_END;
    n_al  += ISSUE_ALONE;
    n_xr  += XLATE_REQ;
    if (WB_EN) {n_wb, wb_d, wb_r} = {n_wb + 1, WB_DATA, WB_REG};
    if (EXC_VALID) {n_exc, ex} = {n_exc + 1, EXC_CODE};
    if (ST_EN) {n_st, sp, sd, sb, ss} = {n_st + 1, ST_PADDR, ST_DATA, ST_BE, ST_SIZE};
end
function automatic logic [31:0] rf(input logic [4:0] rd, input logic [5:0] fn);
    rf = {6'h00, 5'd1, 5'd2, rd, 5'd0, fn};
endfunction
task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
        fails++;
        $display("BAD %0t %s", $time, m);
    end
endtask
task automatic issue(input logic [31:0] i, input logic [63:0] a, b, input int hold, input bit st);
    int k;
    #1;
    {n_acc, n_ge, n_al, n_wb, n_exc, n_xr, n_st} = '0;
    @(posedge CLK);
    {ISSUE_INSTR, SRC_A, SRC_B, ISSUE_VALID} <= {i, a, b, 1'b1};
    // one offer per take: the answer lags a cycle, so holding on would issue twice
    repeat (hold) @(posedge CLK);
    ISSUE_VALID <= 1'b0;
    for (k = 0; k < 30 && (st ? n_st + n_exc : n_acc) == 0; k++) begin
        @(posedge CLK);
        #1;
    end
    @(posedge CLK);
    #1;
    if (k == 30) begin
        fails++;
        report_and_stop();
    end
endtask
task automatic flags(input logic big, swp, fpu, input logic [2:0] e, input logic [1:0] l);
    @(posedge CLK);
    {CPU_BIG_ENDIAN_FLAG, USER_ENDIAN_SWAP_FLAG, FP_USABLE, esel, lat} <= {big, swp, fpu, e, l};
endtask
// ============================================================
// scenarios
task t_alu;
    issue(rf(3, 6'h06), 64'hffffffff80000000, 64'h24, 1, 0);
    chk(n_wb == 1 && wb_r === 5'd3 && wb_d === 64'h8000000, "shift by four");
    issue(rf(3, 6'h06), 64'hffffffff80000000, 64'h20, 1, 0);
    chk(wb_d === 64'hffffffff80000000, "shift by zero");
    issue(rf(5, 6'h22), 64'h7fffffff, '1, 1, 0);
    chk(n_exc == 1 && ex === `ISSE_EXC_OVF && n_wb == 0, "overflow trap");
    issue(rf(5, 6'h22), 64'h5, 64'h7, 1, 0);
    chk(n_wb == 1 && wb_d === 64'hfffffffffffffffe && n_exc == 0, "signed difference");
    issue(rf(6, 6'h23), 64'h7fffffff, '1, 1, 0);
    chk(wb_d === 64'hffffffff80000000 && n_exc == 0, "wrapping difference");
    issue(rf(0, 6'h23), 64'h9, 64'h1, 1, 0);
    chk(n_wb == 0 && n_acc == 1, "zero register write");
endtask
task t_break;
    issue(`ISSE_NOPBRK_WORD, '1, '1, 2, 0);
    chk(n_ge == 1 && n_al == 1 && n_acc == 1 && n_wb + n_exc == 0, "break no-op");
endtask
task t_store;
    flags(0, 1, 1, 0, 0);
    issue({6'h2b, 5'd1, 5'd2, 16'hfff8}, 64'h1010, 64'hdeadbeef12345678, 1, 1);
    chk(sd[31:0] === 32'h12345678 && sb === 8'h0f && sp === 40'h100c && ss === 0, "lo");
    flags(1, 0, 1, 0, 2);
    issue({6'h2b, 5'd1, 5'd2, 16'hfff8}, 64'h1010, 64'hdeadbeef12345678, 1, 1);
    chk(sd[63:32] === 32'h12345678 && sb === 8'hf0 && sp === 40'h1008, "hi word");
    issue({6'h2b, 5'd1, 5'd2, 16'h0002}, 64'h1010, 64'h1, 1, 1);
    chk(ex === `ISSE_EXC_ADES && n_xr + n_st == 0, "word misaligned");
    flags(0, 0, 1, 0, 1);
    issue({6'h39, 5'd1, 5'd3, 16'h0004}, 64'h1010, 64'h0, 1, 1);
    chk(sd[63:32] === FP_DATA[31:0] && sb === 8'hf0 && n_exc == 0, "float word");
    issue({6'h39, 5'd1, 5'd3, 16'h0001}, 64'h1010, 64'h0, 1, 1);
    chk(ex === `ISSE_EXC_ADES && n_st == 0, "float misaligned");
    issue({6'h13, 5'd1, 5'd2, 5'd4, 5'd0, 6'h0d}, 64'h2003, 64'h4, 1, 1);
    chk(sd === FP_DATA && sp === 40'h2000 && ss === 1 && n_exc == 0, "double store");
    chk(XLATE_VADDR === 64'h2000, "double address not aligned");
    flags(0, 0, 1, `ISSE_EXC_TLBINV, 2);
    issue({6'h13, 5'd1, 5'd2, 5'd4, 5'd0, 6'h0d}, 64'h2003, 64'h4, 1, 1);
    chk(ex === `ISSE_EXC_TLBINV && n_st == 0, "translation fault");
    flags(0, 0, 0, 0, 0);
    issue({6'h13, 5'd1, 5'd2, 5'd4, 5'd0, 6'h0d}, 64'h2003, 64'h4, 1, 1);
    chk(ex === `ISSE_EXC_CPU && n_xr + n_st == 0, "unit unusable");
endtask
task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    t_alu();
    t_break();
    t_store();
    report_and_stop();
end
endmodule // test_int_subtract_store_exec
